// *** smd_pkg.sv ***
// package: register map, field layout, opcodes and counts of the arithmetic unit
package smd_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_EXT = 8'h04;
  localparam logic [7:0] REG_OPND = 8'h08;
  localparam logic [7:0] REG_OPND_NEXT = 8'h0C;
  localparam logic [7:0] REG_INSTR = 8'h10;
  localparam logic [7:0] REG_IND = 8'h14;
  localparam logic [7:0] REG_CTRL = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_TEST = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IND_CARRY_BIT = 0;
  localparam int IND_OVF_BIT = 1;
  localparam int CTRL_ODD_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ILL_BIT = 2;
  localparam int ST_CARRY_BIT = 3;
  localparam int ST_OVF_BIT = 4;
  localparam int OP_HI = 15;
  localparam int OP_LO = 11;
  localparam int FMT_BIT = 10;

  // ----------------------------------------------------------------
  // opcodes, reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [4:0] OP_SUB = 5'h12;
  localparam logic [4:0] OP_SUBD = 5'h13;
  localparam logic [4:0] OP_MUL = 5'h14;
  localparam logic [4:0] OP_DIV = 5'h15;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [4:0] MUL_LAST = 5'h0F;
  localparam logic [4:0] DIV_LAST_REDUCE = 5'h0F;
  localparam logic [4:0] DIV_FIX_REM = 5'h10;
  localparam logic [4:0] DIV_FIX_QUO = 5'h11;

  typedef enum {OPK_NONE, OPK_SUB, OPK_SUBD, OPK_MUL, OPK_DIV} smd_op_t;
  typedef enum {ST_IDLE, ST_MUL, ST_DIV} smd_state_t;

  // decode the first instruction word; the two-word forms carry only
  // the indirect bit in the low byte, anything else there is refused
  function automatic smd_op_t smd_decode(input logic [15:0] w);
    smd_op_t k;
    k = OPK_NONE;
    if (!w[FMT_BIT] || (w[6:0] == 7'h00)) begin
      unique case (w[OP_HI:OP_LO])
        OP_SUB: k = OPK_SUB;
        OP_SUBD: k = OPK_SUBD;
        OP_MUL: k = OPK_MUL;
        OP_DIV: k = OPK_DIV;
        default: k = OPK_NONE;
      endcase
    end
    return k;
  endfunction

endpackage

// *** smd_arith_unit.sv ***
// subtract, double subtract, multiply and divide datapath with wishbone registers
//
// Summary of operation
// - subtract storage word from accumulator, store back
// - subtract signed overflow sets sticky overflow indicator
// - overflow is borrow from exactly one top bit
// - carry set on borrow out of accumulator msb
// - single subtract opcodes 90-93, 9400-9780
// - double subtract on accumulator and extension pair
// - odd address subtracts one word from both
// - double subtract overflow is sticky, same test
// - double subtract opcodes 98-9B, 9C00-9F80
// - multiply signed, high product half in accumulator
// - multiply leaves carry and overflow unchanged
// - multiplier bit pairs recoded with previous operation
// - next-low bit picks add or subtract
// - multiply opcodes A0-A3, A400-A780
// - divide: quotient accumulator, remainder extension, dividend sign
// - sixteen sign-compare reduction cycles with shift
// - cycle 17 fixes remainder, 18 exchanges
// - zero divisor or quotient overflow sets overflow
// - divide leaves carry unchanged
// - divide opcodes A8-AB, AC00-AF80
//
// Added by the designer: the address map and the Wishbone slave port.
module smd_arith_unit
  import smd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // indicators and progress
  output logic carry_o,
  output logic overflow_o,
  output logic busy_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] acc;
  logic [15:0] ext;
  logic [15:0] opnd;
  logic [15:0] opnd_next;
  logic carry;
  logic ovf;
  logic odd_addr;
  logic done;
  logic illegal;
  smd_state_t state;
  logic [4:0] cnt;
  logic [15:0] mplier;
  logic [31:0] mcand_sh;
  logic [31:0] prod;
  logic prev_sub;
  logic [17:0] prem;
  logic [15:0] quo;
  logic [15:0] dvsr;
  logic div_neg;
  logic qfix_up;
  logic qfix_dn;

  // byte-lane merge for the 16-bit registers in the low half-word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic busy;
  logic start;
  smd_op_t op_k;

  // a request is taken once; the registered ack closes it
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign busy = (state != ST_IDLE);
  // operands must already stand in their registers when the start lands
  assign start = wr & (wb_adr_i == REG_INSTR) & ~busy;
  assign op_k = smd_decode(wb_dat_i[15:0]);

  // ----------------------------------------------------------------
  // subtract arithmetic
  // ----------------------------------------------------------------
  logic [16:0] sub17;
  logic [15:0] sub_lo;
  logic accumulator_msb;
  logic s_ovf;
  logic [31:0] subtrahend;
  logic [32:0] sub33;
  logic [31:0] subd_lo;
  logic d_ovf;

  // borrow out of the msb is the carry; borrow into it is compared
  assign sub17 = {1'h0, acc} - {1'h0, opnd};
  assign sub_lo = {1'h0, acc[14:0]} - {1'h0, opnd[14:0]};
  assign accumulator_msb = sub17[16];
  assign s_ovf = sub17[16] ^ sub_lo[15];
  // an odd address fetches the same word for both halves
  assign subtrahend = odd_addr ? {opnd, opnd} : {opnd, opnd_next};
  assign sub33 = {1'h0, acc, ext} - {1'h0, subtrahend};
  assign subd_lo = {1'h0, acc[14:0], ext} - {1'h0, subtrahend[30:0]};
  assign d_ovf = sub33[32] ^ subd_lo[31];

  // ----------------------------------------------------------------
  // multiply recoding
  // ----------------------------------------------------------------
  logic multiplier_bit_low;
  logic multiplier_bit_next_low;
  logic multiply_arith_cycle;
  logic [31:0] next_prod;

  assign multiplier_bit_low = mplier[0];
  assign multiplier_bit_next_low = mplier[1];
  // after an add a one calls for work, after a subtract a zero does
  assign multiply_arith_cycle = multiplier_bit_low ^ prev_sub;
  // the next-low bit alone chooses the direction of the step
  always_comb begin
    next_prod = prod;
    if (multiply_arith_cycle) begin
      if (multiplier_bit_next_low) begin
        next_prod = prod - mcand_sh;
      end else begin
        next_prod = prod + mcand_sh;
      end
    end
  end

  // ----------------------------------------------------------------
  // divide reduction and correction
  // ----------------------------------------------------------------
  logic [17:0] dx;
  logic same_sign;
  logic [17:0] prem_sh;
  logic [32:0] n_mag;
  logic [16:0] d_mag;
  logic [32:0] lim_pos;
  logic [32:0] lim_neg;
  logic div_ovf;
  logic rem_eq_pos;
  logic rem_eq_neg;
  logic rem_wrong;
  logic [15:0] quo_raw;
  logic [15:0] quo_fixed;

  assign dx = {{2{dvsr[15]}}, dvsr};
  // the sign compare picks the step and the quotient bit at once
  assign same_sign = (prem[17] == dvsr[15]);
  assign prem_sh = {prem[16:0], quo[15]};

  // range check up front: unsigned compare of magnitudes avoids a
  // wide divider; the negative side admits one more multiple
  always_comb begin
    n_mag = acc[15] ? (33'h000000000 - {1'h1, acc, ext}) : {1'h0, acc, ext};
    d_mag = opnd[15] ? (17'h00000 - {1'h1, opnd}) : {1'h0, opnd};
    lim_pos = {1'h0, d_mag, 15'h0000};
    lim_neg = lim_pos + {16'h0000, d_mag};
    if (opnd == 16'h0000) begin
      div_ovf = 1'h1;
    end else if (acc[15] == opnd[15]) begin
      div_ovf = (n_mag >= lim_pos);
    end else begin
      div_ovf = (n_mag >= lim_neg);
    end
  end

  // remainder must be below the divisor and carry the dividend sign
  assign rem_eq_pos = (prem == dx);
  assign rem_eq_neg = (prem == (18'h00000 - dx));
  assign rem_wrong = (prem != 18'h00000) & (prem[17] != div_neg);
  // quotient digits are +1/-1, so the settled value ends in a one
  assign quo_raw = {quo[14:0], 1'h1};
  always_comb begin
    quo_fixed = quo_raw;
    if (qfix_up) begin
      quo_fixed = quo_raw + 16'h0001;
    end else if (qfix_dn) begin
      quo_fixed = quo_raw - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cnt <= 5'h00;
          if (start && (op_k == OPK_MUL)) begin
            state <= ST_MUL;
          end else if (start && (op_k == OPK_DIV) && !div_ovf) begin
            state <= ST_DIV;
          end
        end
        ST_MUL: begin
          cnt <= cnt + 5'h01;
          if (cnt == MUL_LAST) begin
            state <= ST_IDLE;
          end
        end
        ST_DIV: begin
          cnt <= cnt + 5'h01;
          if (cnt == DIV_FIX_QUO) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // done and illegal flags; a new start reloads both, setting done at once when nothing is left to run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done <= 1'h0;
      illegal <= 1'h0;
    end else if (start) begin
      illegal <= (op_k == OPK_NONE);
      done <= (op_k == OPK_SUB) || (op_k == OPK_SUBD) ||
              ((op_k == OPK_DIV) && div_ovf) || (op_k == OPK_NONE);
    end else if ((state == ST_MUL) && (cnt == MUL_LAST)) begin
      done <= 1'h1;
    end else if ((state == ST_DIV) && (cnt == DIV_FIX_QUO)) begin
      done <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // accumulator and extension
  // ----------------------------------------------------------------
  // software writes are ignored while an operation runs, since the
  // datapath owns both words then
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= RST_WORD;
      ext <= RST_WORD;
    end else if (start && (op_k == OPK_SUB)) begin
      acc <= sub17[15:0];
    end else if (start && (op_k == OPK_SUBD)) begin
      acc <= sub33[31:16];
      ext <= sub33[15:0];
    end else if ((state == ST_MUL) && (cnt == MUL_LAST)) begin
      acc <= next_prod[31:16];
      ext <= next_prod[15:0];
    end else if ((state == ST_DIV) && (cnt == DIV_FIX_QUO)) begin
      acc <= quo_fixed;
      ext <= prem[15:0];
    end else if (wr && !busy && (wb_adr_i == REG_ACC)) begin
      acc <= merge16(acc, wb_dat_i, wb_sel_i);
    end else if (wr && !busy && (wb_adr_i == REG_EXT)) begin
      ext <= merge16(ext, wb_dat_i, wb_sel_i);
    end
  end

  // operand words as fetched from storage, and the address parity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opnd <= RST_WORD;
      opnd_next <= RST_WORD;
      odd_addr <= 1'h0;
    end else if (wr) begin
      if (!busy && (wb_adr_i == REG_OPND)) begin
        opnd <= merge16(opnd, wb_dat_i, wb_sel_i);
      end
      if (!busy && (wb_adr_i == REG_OPND_NEXT)) begin
        opnd_next <= merge16(opnd_next, wb_dat_i, wb_sel_i);
      end
      if ((wb_adr_i == REG_CTRL) && wb_sel_i[0]) begin
        odd_addr <= wb_dat_i[CTRL_ODD_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // multiply datapath
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mplier <= RST_WORD;
      mcand_sh <= 32'h00000000;
      prod <= 32'h00000000;
      prev_sub <= 1'h0;
    end else if (start && (op_k == OPK_MUL)) begin
      mplier <= acc;
      mcand_sh <= {{16{opnd[15]}}, opnd};
      prod <= 32'h00000000;
      prev_sub <= 1'h0;
    end else if (state == ST_MUL) begin
      prod <= next_prod;
      mcand_sh <= {mcand_sh[30:0], 1'h0};
      // arithmetic shift keeps the sign under the next-low bit
      mplier <= {mplier[15], mplier[15:1]};
      if (multiply_arith_cycle) begin
        prev_sub <= multiplier_bit_next_low;
      end
    end
  end

  // ----------------------------------------------------------------
  // divide datapath
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prem <= 18'h00000;
      quo <= RST_WORD;
      dvsr <= RST_WORD;
      div_neg <= 1'h0;
      qfix_up <= 1'h0;
      qfix_dn <= 1'h0;
    end else if (start && (op_k == OPK_DIV)) begin
      prem <= {{2{acc[15]}}, acc};
      quo <= ext;
      dvsr <= opnd;
      div_neg <= acc[15];
      qfix_up <= 1'h0;
      qfix_dn <= 1'h0;
    end else if ((state == ST_DIV) && (cnt <= DIV_LAST_REDUCE)) begin
      // shift left first, then add or subtract
      quo <= {quo[14:0], same_sign};
      if (same_sign) begin
        prem <= prem_sh - dx;
      end else begin
        prem <= prem_sh + dx;
      end
    end else if ((state == ST_DIV) && (cnt == DIV_FIX_REM)) begin
      if (rem_eq_pos || (rem_wrong && same_sign)) begin
        prem <= prem - dx;
        qfix_up <= 1'h1;
      end else if (rem_eq_neg || rem_wrong) begin
        prem <= prem + dx;
        qfix_dn <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  logic ind_wr;
  logic test_rd;
  logic ovf_set;
  logic next_ovf;

  assign ind_wr = wr & (wb_adr_i == REG_IND) & wb_sel_i[0];
  assign test_rd = rd & (wb_adr_i == REG_TEST);
  // multiply never raises overflow: the product always fits
  assign ovf_set = start & (((op_k == OPK_SUB) & s_ovf) |
                            ((op_k == OPK_SUBD) & d_ovf) |
                            ((op_k == OPK_DIV) & div_ovf));

  // load, or a test read, may clear; a new overflow wins the cycle
  always_comb begin
    next_ovf = ovf;
    if (ind_wr) begin
      next_ovf = wb_dat_i[IND_OVF_BIT];
    end else if (test_rd) begin
      next_ovf = 1'h0;
    end
    next_ovf = next_ovf | ovf_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf <= 1'h0;
    end else begin
      ovf <= next_ovf;
    end
  end

  // carry moves only on subtracts and on a status load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry <= 1'h0;
    end else if (start && ((op_k == OPK_SUB) || (op_k == OPK_SUBD))) begin
      carry <= (op_k == OPK_SUB) ? accumulator_msb : sub33[32];
    end else if (ind_wr) begin
      carry <= wb_dat_i[IND_CARRY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h00000000;
    unique case (wb_adr_i)
      REG_ACC: rd_word[15:0] = acc;
      REG_EXT: rd_word[15:0] = ext;
      REG_OPND: rd_word[15:0] = opnd;
      REG_OPND_NEXT: rd_word[15:0] = opnd_next;
      REG_CTRL: rd_word[CTRL_ODD_BIT] = odd_addr;
      REG_IND, REG_TEST: begin
        rd_word[IND_CARRY_BIT] = carry;
        rd_word[IND_OVF_BIT] = ovf;
      end
      REG_STATUS: begin
        rd_word[ST_BUSY_BIT] = busy;
        rd_word[ST_DONE_BIT] = done;
        rd_word[ST_ILL_BIT] = illegal;
        rd_word[ST_CARRY_BIT] = carry;
        rd_word[ST_OVF_BIT] = ovf;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // every access, mapped or not, gets one registered ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // outputs straight from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'h0;
    end else begin
      busy_o <= (state != ST_IDLE) || (start && ((op_k == OPK_MUL) ||
                ((op_k == OPK_DIV) && !div_ovf)));
    end
  end

  assign carry_o = carry;
  assign overflow_o = ovf;

endmodule

// *** smd_arith_unit_asserts.sv ***
// checker: bus handshake and indicator properties of the arithmetic unit
module smd_arith_unit_chk
  import smd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  // indicators and progress
  input wire logic carry_o,
  input wire logic overflow_o,
  input wire logic busy_o
);
  // ---------------------------------------------
  // helper logic
  // ---------------------------------------------
  logic req;
  logic op_go;
  logic ind_acc;
  logic [5:0] blen;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign op_go = req && wb_we_i && (wb_adr_i == REG_INSTR);
  assign ind_acc = req && (wb_we_i ? (wb_adr_i == REG_IND) : (wb_adr_i == REG_TEST));
  // busy stretch length, so a hung sequencer shows as a count overrun
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      blen <= 6'h00;
    end else begin
      blen <= blen + 6'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_ovf_sticky; overflow_o && !ind_acc |=> overflow_o; endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");
  property p_ovf_cause; $rose(overflow_o) |-> $past(op_go || (ind_acc && wb_we_i)); endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow uncaused");
  property p_carry_cause; $changed(carry_o) |-> $past(op_go || (ind_acc && wb_we_i)); endproperty
  a_carry_cause: assert property (p_carry_cause) else $error("carry uncaused");
  property p_flags_hold; $past(busy_o) |-> $stable(carry_o) && $stable(overflow_o); endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flag moved");
  property p_busy_start; $rose(busy_o) |-> $past(op_go) || $past(op_go, 2); endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy uncaused");
  property p_busy_max; blen <= 6'h14; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_min; $fell(busy_o) |-> blen >= 6'h0E; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  c_busy: cover property ($rose(busy_o));
  c_ovf: cover property ($rose(overflow_o));
  c_clear: cover property (ind_acc && overflow_o);
endmodule
bind smd_arith_unit smd_arith_unit_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .carry_o(carry_o), .overflow_o(overflow_o), .busy_o(busy_o));

// *** smd_store_model.sv ***
// core storage model that supplies the operand word pair
module smd_store_model
  import smd_pkg::*;
(
  // clock
  input wire logic clk_i,
  // set-up port
  input wire logic wr_i,
  input wire logic [3:0] adr_i,
  input wire logic [15:0] dat_i,
  // operand read
  output logic [15:0] word_o,
  output logic [15:0] next_o,
  output logic odd_o
);
  logic [15:0] mem [16];
  // only the bench writes; operations never change storage
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[adr_i] <= dat_i;
    end
  end
  // word pair at the address and the next higher one; odd warns the unit
  assign word_o = mem[adr_i];
  assign next_o = mem[adr_i + 4'h1];
  assign odd_o = adr_i[0];
endmodule

// *** tb_top.sv ***
// testbench: register-level tests of the arithmetic unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import smd_pkg::*;
  // ---------------------------------------------
  // signals and instances
  // ---------------------------------------------
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat;
  logic ack, carry, ovf, busy;
  logic swr = 1'h0;
  logic [3:0] sadr = 4'h0;
  logic [15:0] sdat = 16'h0000;
  logic [15:0] sword, snext;
  logic sodd;
  logic c_x = 1'h0;
  logic v_x = 1'h0;
  int failures = 0;
  int compares = 0;
  `define CHK(n, e, g) \
    begin \
      compares++; \
      if ((g) !== (e)) begin \
        failures++; \
        $display("wrong value %s: expected %h seen %h", n, e, g); \
      end \
    end
  always #4 clk = ~clk;
  smd_arith_unit u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .carry_o(carry), .overflow_o(ovf), .busy_o(busy));
  smd_store_model u_store (.clk_i(clk), .wr_i(swr), .adr_i(sadr), .dat_i(sdat),
    .word_o(sword), .next_o(snext), .odd_o(sodd));
  // one classic cycle; holds everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    @(posedge clk);
    // only the watchdog ends this wait
    while (ack !== 1'h1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  // load operands, start, wait for done, compare with the bench's own model
  task automatic run(input logic [15:0] ins, a, e, m1, m2, input logic [3:0] sa,
                     input logic pk);
    logic [31:0] q, x, y;
    logic [32:0] d;
    longint dv, qq;
    logic sk, il;
    int n;
    sk = 1'h0;
    il = 1'h0;
    x = {a, e};
    y = {m1, (sa[0] ? m1 : m2)};
    swr <= 1'h1;
    sadr <= sa + 4'h1;
    sdat <= m2;
    @(posedge clk);
    sadr <= sa;
    sdat <= m1;
    @(posedge clk);
    swr <= 1'h0;
    @(posedge clk);
    bus(1'h1, REG_OPND, sword, q);
    bus(1'h1, REG_OPND_NEXT, snext, q);
    bus(1'h1, REG_CTRL, {15'h0000, sodd}, q);
    bus(1'h1, REG_ACC, a, q);
    bus(1'h1, REG_EXT, e, q);
    bus(1'h1, REG_INSTR, ins, q);
    if (pk) begin
      // writes while busy must be swallowed
      `CHK("busy", 1'h1, busy);
      bus(1'h1, REG_ACC, 16'h1234, q);
      bus(1'h1, REG_INSTR, 16'h9000, q);
    end
    case ((ins[10] && ins[6:0] != 7'h00) ? 5'h00 : ins[15:11])
      OP_SUB: begin
        d = {17'h00000, a} - {17'h00000, m1};
        v_x = v_x | ((a[15] != m1[15]) && (d[15] != a[15]));
        c_x = d[16];
        x[31:16] = d[15:0];
      end
      OP_SUBD: begin
        d = {1'h0, x} - {1'h0, y};
        v_x = v_x | ((x[31] != y[31]) && (d[31] != x[31]));
        c_x = d[32];
        x = d[31:0];
      end
      OP_MUL: x = $signed(a) * $signed(m1);
      OP_DIV: begin
        dv = $signed(x);
        qq = (m1 == 16'h0000) ? 0 : dv / $signed(m1);
        if (m1 == 16'h0000 || qq > 32767 || qq < -32768) begin
          v_x = 1'h1;
          sk = 1'h1;
        end else begin
          x = {16'(qq), 16'(dv % $signed(m1))};
        end
      end
      default: il = 1'h1;
    endcase
    n = 0;
    do begin
      bus(1'h0, REG_STATUS, 16'h0000, q);
      n++;
    end while (q[ST_DONE_BIT] !== 1'h1 && n < 40);
    if (n >= 40) failures++;
    `CHK("illegal", il, q[ST_ILL_BIT]);
    `CHK("st", {v_x, c_x, 1'h0}, {q[ST_OVF_BIT], q[ST_CARRY_BIT], q[ST_BUSY_BIT]});
    `CHK("ports", {v_x, c_x, 1'h0}, {ovf, carry, busy});
    bus(1'h0, REG_IND, 16'h0000, q);
    `CHK("ind", {v_x, c_x}, q[1:0]);
    if (!sk) begin
      bus(1'h0, REG_ACC, 16'h0000, q);
      `CHK("acc", x[31:16], q[15:0]);
      bus(1'h0, REG_EXT, 16'h0000, q);
      `CHK("ext", x[15:0], q[15:0]);
    end
  endtask
  // reading the test place reports both flags and drops overflow
  task automatic test_clear();
    logic [31:0] q;
    bus(1'h0, REG_TEST, 16'h0000, q);
    `CHK("test", {30'h0, v_x, c_x}, q);
    v_x = 1'h0;
  endtask
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    logic [31:0] q;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // everything reads zero after reset, the unmapped word too
    for (int i = 0; i < 10; i++) begin
      bus(1'h0, 8'(i * 4), 16'h0000, q);
      `CHK("reset", 32'h0000_0000, q);
    end
    // every opcode form of the four operations
    for (int k = 0; k < 4; k++) begin
      for (int f = 0; f < 12; f++) begin
        run({8'(8'h90 + 8 * k + (f < 8 ? f : f - 4)), (f < 4 ? 8'h5A : (f < 8 ? 8'h00 : 8'h80))},
            16'h0012, 16'h5678, 16'h0ABC, 16'h0123, 4'h2, 1'h0);
      end
    end
    run(16'h9000, 16'h0005, 16'h0000, 16'h0007, 16'h0000, 4'h2, 1'h0);
    run(16'h9100, 16'h8000, 16'h0000, 16'h0001, 16'h0000, 4'h2, 1'h0);
    run(16'h9000, 16'h0003, 16'h0000, 16'h0001, 16'h0000, 4'h2, 1'h0);
    test_clear();
    run(16'h9200, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h0000, 4'h2, 1'h0);
    run(16'h9800, 16'h0005, 16'h0009, 16'h0002, 16'h0001, 4'h3, 1'h0);
    run(16'h9C00, 16'h8000, 16'h0000, 16'h0000, 16'h0001, 4'h4, 1'h0);
    run(16'h9C80, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 4'h6, 1'h0);
    run(16'hA000, 16'h8000, 16'h0000, 16'h8000, 16'h0000, 4'h2, 1'h1);
    run(16'hA100, 16'hFFFF, 16'h0000, 16'h0003, 16'h0000, 4'h2, 1'h0);
    run(16'hA400, 16'h5555, 16'h0000, 16'h8001, 16'h0000, 4'h2, 1'h0);
    test_clear();
    run(16'hA800, 16'h0000, 16'h0039, 16'h0005, 16'h0000, 4'h2, 1'h1);
    run(16'hA800, 16'hFFFF, 16'hFFC7, 16'h0005, 16'h0000, 4'h2, 1'h0);
    run(16'hAC00, 16'h0000, 16'h0039, 16'hFFFB, 16'h0000, 4'h2, 1'h0);
    run(16'hAC80, 16'h0000, 16'h0036, 16'hFFF7, 16'h0000, 4'h2, 1'h0);
    run(16'hA800, 16'h1234, 16'h0000, 16'h0000, 16'h0000, 4'h2, 1'h0);
    test_clear();
    run(16'hA900, 16'h7FFF, 16'h0000, 16'h0001, 16'h0000, 4'h2, 1'h0);
    run(16'h8000, 16'h0011, 16'h0022, 16'h0033, 16'h0000, 4'h2, 1'h0);
    run(16'h9401, 16'h0011, 16'h0022, 16'h0033, 16'h0000, 4'h2, 1'h0);
    // a status load sets overflow and drops carry in one access
    bus(1'h1, REG_IND, 16'h0002, q);
    v_x = 1'h1;
    c_x = 1'h0;
    test_clear();
    // a lane-masked write merges only the upper byte
    sel <= 4'h2;
    bus(1'h1, REG_EXT, 16'hABCD, q);
    sel <= 4'hF;
    bus(1'h0, REG_EXT, 16'h0000, q);
    `CHK("lane", 16'hAB22, q[15:0]);
    end_sim();
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule
